/* File: logic/event_ctrl_pkg.sv */
// Constants and carrier types for the two-stage event controller
package event_ctrl_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_LEVELS  = 16;
	localparam int NUM_GP      = 9;
	localparam int NUM_SOURCES = 32;
	localparam int NUM_DED     = 6;
	localparam int NUM_ASSIGN  = 4;
	localparam int WORD_W      = 32;
	localparam int EDGE_CYCLES = 2;
	localparam int MIN_LATENCY = 3;
	// ==========================================================
	// Register indices
	localparam logic [3:0] IDX_LATCH   = 4'h0;
	localparam logic [3:0] IDX_MASK    = 4'h1;
	localparam logic [3:0] IDX_PENDING = 4'h2;
	localparam logic [3:0] IDX_SYS_MSK = 4'h3;
	localparam logic [3:0] IDX_SYS_STS = 4'h4;
	localparam logic [3:0] IDX_SYS_WAK = 4'h5;
	localparam logic [3:0] IDX_ASSIGN0 = 4'h6;
	// ==========================================================
	// Levels, field positions and reset values
	localparam logic [3:0]   LVL_GP_FIRST   = 4'h7;
	localparam logic [4:0]   LVL_NONE       = 5'h10;
	localparam logic [15:0]  UNMASKABLE     = 16'h001f;
	localparam logic [15:0]  GP_LEVELS      = 16'hff80;
	localparam logic [15:0]  RESET_LEVELS   = 16'h0000;
	localparam logic [15:0]  RESET_CORE_MSK = 16'h001f;
	localparam logic         RESET_GLOBAL   = 1'b0;
	localparam logic [31:0]  RESET_WORD     = 32'h00000000;
	localparam logic [127:0] DEFAULT_ASSIGN = 128'h33333332_22222221_10000000_00000000;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        supervisor;
		logic [3:0]  index;
		logic [31:0] wdata;
	} mmr_req_t;
	typedef struct packed {
		logic       accept;
		logic [3:0] accept_level;
		logic       ret;
		logic [3:0] return_level;
	} core_ack_t;
	typedef struct packed {
		logic tick;
		logic hwerr;
		logic exc;
		logic nmi;
		logic rst;
		logic emu;
	} core_events_t;
endpackage

/* File: logic/event_edge_detect.sv */
// Rising edge detector, with optional three-flop synchroniser per bit
`timescale 1ns/1ps
module event_edge_detect
#(
	parameter int WIDTH = 9,
	parameter bit SYNC  = 1'b0
)
(
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] rise_out
);
	// ==========================================================
	// Per-bit detection
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		if (SYNC)
		begin : g_sync
			logic s1, s2, s3, lvl;
			always_ff @(posedge clk_in)
			begin
				if (!rst_n_in)
				begin
					s1  <= 1'b0;
					s2  <= 1'b0;
					s3  <= 1'b0;
					lvl <= 1'b0;
				end
				else
				begin
					s1 <= level_in[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3)
					begin
						lvl <= s3;
					end
				end
			end
			assign rise_out[i] = (s2 == s3) && s3 && !lvl;
		end
		else
		begin : g_direct
			logic q, lvl;
			always_ff @(posedge clk_in)
			begin
				if (!rst_n_in)
				begin
					q   <= 1'b0;
					lvl <= 1'b0;
				end
				else
				begin
					q   <= level_in[i];
					lvl <= q;
				end
			end
			assign rise_out[i] = q && !lvl;
		end
	end
endmodule // event_edge_detect

/* File: logic/system_event_stage.sv */
// System stage: source mask, status, wakeup, assignment and routing
`timescale 1ns/1ps
module system_event_stage
#(
	parameter int SOURCES = event_ctrl_pkg::NUM_SOURCES,
	parameter int GP      = event_ctrl_pkg::NUM_GP
)
(
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic [SOURCES-1:0] source_req_in,
	input  wire logic [GP-1:0]      gp_pending_in,
	input  wire logic               idle_in,
	input  wire logic               mask_we_in,
	input  wire logic               wakeup_we_in,
	input  wire logic [3:0]         assign_we_in,
	input  wire logic [31:0]        wdata_in,
	output logic      [SOURCES-1:0] mask_out,
	output logic      [SOURCES-1:0] status_out,
	output logic      [SOURCES-1:0] wakeup_out,
	output logic      [127:0]       assign_out,
	output logic      [GP-1:0]      gp_line_out,
	output logic                    wake_out
);
	import event_ctrl_pkg::*;

	logic [GP-1:0]              ack_q;
	logic [GP-1:0]              any_req;
	logic [GP-1:0][SOURCES-1:0] hit;

	// ==========================================================
	// Registers
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			mask_out   <= SOURCES'(RESET_WORD);
			wakeup_out <= SOURCES'(RESET_WORD);
			assign_out <= DEFAULT_ASSIGN;
		end
		else
		begin
			if (mask_we_in)
			begin
				mask_out <= wdata_in[SOURCES-1:0];
			end
			if (wakeup_we_in)
			begin
				wakeup_out <= wdata_in[SOURCES-1:0];
			end
			for (int k = 0; k < NUM_ASSIGN; k++)
			begin
				if (assign_we_in[k])
				begin
					assign_out[k*32 +: 32] <= wdata_in;
				end
			end
		end
	end

	// ==========================================================
	// Routing onto the general inputs
	for (genvar g = 0; g < GP; g++)
	begin : g_route
		for (genvar s = 0; s < SOURCES; s++)
		begin : g_src
			assign hit[g][s] = source_req_in[s] && mask_out[s]
				&& (assign_out[s*4 +: 4] == 4'(g));
		end
		assign any_req[g] = |hit[g];
	end

	// ==========================================================
	// Status, wakeup and acknowledge
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			status_out  <= SOURCES'(RESET_WORD);
			wake_out    <= 1'b0;
			ack_q       <= '0;
			gp_line_out <= '0;
		end
		else
		begin
			status_out  <= source_req_in;
			wake_out    <= idle_in && |(source_req_in & wakeup_out);
			ack_q       <= gp_pending_in;
			gp_line_out <= any_req & ~(gp_pending_in & ~ack_q);
		end
	end
endmodule // system_event_stage

/* File: logic/two_stage_event_controller.sv */
// Two-stage event controller top with the core stage registers
//
// Behaviour
// - Core latch, mask and pending are 16-bit, one bit per event.
// - Latch bit sets on capture and clears once the event is accepted.
// - Software may write the latch register to cancel latched events.
// - Latch write acts only in supervisor mode and where the mask bit is zero.
// - Mask one lets an event be serviced; zero blocks it, latch may stay.
// - Core mask register is readable and writable in supervisor mode.
// - Global on and off instructions gate all general inputs.
// - Pending is hardware kept, one bit per active or nested event, supervisor read.
// - System stage has three 32-bit registers, one bit per source.
// - System mask one passes a source request; zero blocks it.
// - System status bit reads one while its source asserts a request.
// - Wakeup-enabled source raising an event while idle wakes the core.
// - Several sources share one general input; overlapping pulses are tolerated.
// - System stage takes core pending bits as the acknowledgement.
// - Latch bit sets on a rising edge; detection takes two cycles for general inputs, four for dedicated events through the synchroniser.
// - Latch bit clears when its pending bit sets.
// - After pending sets, the next rising edge on that input is queued.
// - At least three cycles from input edge to pending bit.
// - Nine general inputs besides the dedicated events.
// - Default source mapping, changeable through assignment registers.
// - Higher priority events preempt lower ones, nesting them.
`timescale 1ns/1ps
module two_stage_event_controller
(
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic [31:0]                 source_req_in,
	input  wire event_ctrl_pkg::core_events_t core_events_in,
	input  wire event_ctrl_pkg::core_ack_t   core_ack_in,
	input  wire logic                        global_on_in,
	input  wire logic                        global_off_in,
	input  wire logic                        idle_in,
	input  wire event_ctrl_pkg::mmr_req_t    mmr_req_in,
	output logic      [31:0]                 mmr_rdata_out,
	output logic                             mmr_ack_out,
	output logic                             request_out,
	output logic      [3:0]                  request_level_out,
	output logic                             global_enable_out,
	output logic                             wake_out
);
	import event_ctrl_pkg::*;

	logic [15:0]           latch;
	logic [15:0]           mask;
	logic [15:0]           pending;
	logic [15:0]           next_latch;
	logic [15:0]           next_pending;
	logic [15:0]           rise16;
	logic [15:0]           sw_clear;
	logic [15:0]           accept_hot;
	logic [15:0]           return_hot;
	logic [15:0]           eligible;
	logic [4:0]            next_cand;
	logic [4:0]            next_active;
	logic [NUM_GP-1:0]     gp_line;
	logic [NUM_GP-1:0]     gp_rise;
	logic [NUM_DED-1:0]    ded_rise;
	logic [31:0]           sys_mask;
	logic [31:0]           sys_status;
	logic [31:0]           sys_wakeup;
	logic [127:0]          sys_assign;
	logic [NUM_ASSIGN-1:0] assign_we;
	logic                  sv_write;
	logic                  sys_wake;
	logic [31:0]           read_word;

	// ==========================================================
	// Priority search, lowest index wins
	function automatic logic [4:0] lowest_set(input logic [15:0] v);
		logic [4:0] idx;
		idx = LVL_NONE;
		for (int i = NUM_LEVELS - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction

	// ==========================================================
	// System stage
	system_event_stage #(
		.SOURCES (NUM_SOURCES),
		.GP      (NUM_GP)
	) u_system (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.source_req_in (source_req_in),
		.gp_pending_in (pending[15:7]),
		.idle_in       (idle_in),
		.mask_we_in    (sv_write && mmr_req_in.index == IDX_SYS_MSK),
		.wakeup_we_in  (sv_write && mmr_req_in.index == IDX_SYS_WAK),
		.assign_we_in  (assign_we),
		.wdata_in      (mmr_req_in.wdata),
		.mask_out      (sys_mask),
		.status_out    (sys_status),
		.wakeup_out    (sys_wakeup),
		.assign_out    (sys_assign),
		.gp_line_out   (gp_line),
		.wake_out      (sys_wake)
	);

	// ==========================================================
	// Edge detection
	event_edge_detect #(
		.WIDTH (NUM_GP),
		.SYNC  (1'b0)
	) u_gp_edge (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.level_in (gp_line),
		.rise_out (gp_rise)
	);

	event_edge_detect #(
		.WIDTH (NUM_DED),
		.SYNC  (1'b1)
	) u_ded_edge (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.level_in (core_events_in),
		.rise_out (ded_rise)
	);

	assign rise16 = {gp_rise, ded_rise[5:4], 1'b0, ded_rise[3:0]};

	// ==========================================================
	// Next-state terms
	assign sv_write   = mmr_req_in.valid && mmr_req_in.write && mmr_req_in.supervisor;
	assign sw_clear   = (sv_write && mmr_req_in.index == IDX_LATCH)
		? (mmr_req_in.wdata[15:0] & ~mask) : RESET_LEVELS;
	assign accept_hot = core_ack_in.accept ? (16'h1 << core_ack_in.accept_level)
		: RESET_LEVELS;
	assign return_hot = core_ack_in.ret ? (16'h1 << core_ack_in.return_level)
		: RESET_LEVELS;
	assign next_latch   = (latch & ~sw_clear & ~accept_hot) | rise16;
	assign next_pending = (pending & ~return_hot) | accept_hot;
	assign eligible     = next_latch & mask
		& (global_enable_out ? 16'hffff : ~GP_LEVELS);
	assign next_cand    = lowest_set(eligible);
	assign next_active  = lowest_set(next_pending);

	always_comb
	begin
		for (int k = 0; k < NUM_ASSIGN; k++)
		begin
			assign_we[k] = sv_write && (mmr_req_in.index == IDX_ASSIGN0 + 4'(k));
		end
	end

	// ==========================================================
	// Core stage registers
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			latch   <= RESET_LEVELS;
			pending <= RESET_LEVELS;
		end
		else
		begin
			latch   <= next_latch;
			pending <= next_pending;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			mask <= RESET_CORE_MSK;
		end
		else if (sv_write && mmr_req_in.index == IDX_MASK)
		begin
			mask <= mmr_req_in.wdata[15:0] | UNMASKABLE;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			global_enable_out <= RESET_GLOBAL;
		end
		else if (global_off_in)
		begin
			global_enable_out <= 1'b0;
		end
		else if (global_on_in)
		begin
			global_enable_out <= 1'b1;
		end
	end

	// ==========================================================
	// Request to the core pipeline
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			request_out       <= 1'b0;
			request_level_out <= 4'h0;
			wake_out          <= 1'b0;
		end
		else
		begin
			request_out       <= next_cand < next_active;
			request_level_out <= next_cand[3:0];
			wake_out          <= sys_wake;
		end
	end

	// ==========================================================
	// Register reads
	always_comb
	begin
		case (mmr_req_in.index)
			IDX_LATCH:       read_word = 32'(latch);
			IDX_MASK:        read_word = 32'(mask);
			IDX_PENDING:     read_word = 32'(pending);
			IDX_SYS_MSK:     read_word = sys_mask;
			IDX_SYS_STS:     read_word = sys_status;
			IDX_SYS_WAK:     read_word = sys_wakeup;
			IDX_ASSIGN0:     read_word = sys_assign[31:0];
			IDX_ASSIGN0 + 4'h1: read_word = sys_assign[63:32];
			IDX_ASSIGN0 + 4'h2: read_word = sys_assign[95:64];
			IDX_ASSIGN0 + 4'h3: read_word = sys_assign[127:96];
			default:         read_word = RESET_WORD;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			mmr_rdata_out <= RESET_WORD;
			mmr_ack_out   <= 1'b0;
		end
		else
		begin
			mmr_ack_out   <= mmr_req_in.valid;
			mmr_rdata_out <= (mmr_req_in.valid && !mmr_req_in.write && mmr_req_in.supervisor)
				? read_word : RESET_WORD;
		end
	end

	// ==========================================================
	// Assertions
	a_latch_on_edge:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		|rise16 |=> ((latch & $past(rise16)) == $past(rise16)))
		else $error("Detected edge not latched");

	a_accept_clears:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		core_ack_in.accept && !(|(rise16 & accept_hot))
		|=> !(|(latch & $past(accept_hot))) && (|(pending & $past(accept_hot))))
		else $error("Accept did not move latch bit to pending");

	a_mask_blocks:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		request_out && $stable(mask) |-> mask[request_level_out])
		else $error("Masked event requested");

	a_global_off:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		global_off_in |=> ##1 !(request_out && request_level_out >= LVL_GP_FIRST))
		else $error("General event requested while globally disabled");

	a_latch_guard:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		mmr_req_in.valid && mmr_req_in.write && !mmr_req_in.supervisor
		&& mmr_req_in.index == IDX_LATCH && !core_ack_in.accept && !(|rise16)
		|=> latch == $past(latch))
		else $error("Unprivileged write changed latch");

	a_min_latency:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(gp_line[0]) && !pending[7] && !latch[7] |=> !pending[7] [*2])
		else $error("Pending set sooner than three cycles");

	a_read_priv:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		mmr_req_in.valid && !mmr_req_in.supervisor |=> mmr_rdata_out == RESET_WORD)
		else $error("Register readable outside supervisor mode");

	a_wake_idle:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		idle_in && |(source_req_in & sys_wakeup) |=> ##1 wake_out)
		else $error("Wakeup source did not wake core");

	a_status_follow:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		##1 sys_status == $past(source_req_in))
		else $error("Status does not follow source requests");

	a_nest_order:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		request_out |-> !(|(pending & ((16'h2 << request_level_out) - 16'h1))))
		else $error("Request does not preempt active event");

	a_latch_cancel:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sv_write && mmr_req_in.index == IDX_LATCH && !(|rise16)
		|=> !(|(latch & $past(mmr_req_in.wdata[15:0] & ~mask))))
		else $error("Latch write did not cancel unmasked bits");
	a_latch_keep:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sv_write && mmr_req_in.index == IDX_LATCH && !core_ack_in.accept && !(|rise16)
		|=> (latch & $past(mask)) == $past(latch & mask))
		else $error("Latch write changed a bit whose mask is set");
	a_mask_write:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sv_write && mmr_req_in.index == IDX_MASK
		|=> mask[15:5] == $past(mmr_req_in.wdata[15:5]) && &mask[4:0])
		else $error("Core mask write not taken");
	a_global_cmd:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		global_on_in || global_off_in |=> global_enable_out == !$past(global_off_in))
		else $error("Global enable does not follow instruction");
	a_sys_block:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(|(source_req_in & sys_mask)) |=> !(|gp_line))
		else $error("Masked source reached a general input");
	a_ack_drop:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(pending[7]) |=> !gp_line[0])
		else $error("Pending bit not used as acknowledgement");
	a_requeue:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		pending[7] && gp_rise[0] |=> latch[7])
		else $error("Edge during service not queued");
	a_wake_busy:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!idle_in |=> ##1 !wake_out)
		else $error("Wake raised while core busy");
	a_return_clears:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		core_ack_in.ret && !core_ack_in.accept
		|=> !(|(pending & $past(return_hot))))
		else $error("Return did not clear pending bit");
	a_bus_ack:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		mmr_req_in.valid |=> mmr_ack_out)
		else $error("Register access not acknowledged");
	a_rise_two:
	assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(gp_line[0]) && !latch[7] |=> !latch[7] ##1 latch[7])
		else $error("Edge detection did not take two cycles");
endmodule // two_stage_event_controller

/* File: sim/core_pipe_model.sv */
// Processor pipeline model that accepts requested events and returns from them
`timescale 1ns/1ps
module core_pipe_model
(
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 request_in,
	input  wire logic [3:0]           request_level_in,
	input  wire logic                 accept_en_in,
	input  wire logic                 ret_go_in,
	output event_ctrl_pkg::core_ack_t ack_out
);
	import event_ctrl_pkg::*;
	logic [15:0] active;
	logic [3:0]  top;
	logic [1:0]  gap;
	// ==========================================================
	// Highest ranked active level is the one returned from first
	always_comb
	begin
		top = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (active[i])
				top = 4'(i);
	end
	// ==========================================================
	// Accept with a short holdoff, return on command
	always_ff @(posedge clk_in)
	begin
		ack_out <= '0;
		gap <= (gap != 2'h0) ? gap - 2'h1 : 2'h0;
		if (!rst_n_in)
		begin
			active <= '0;
			gap <= 2'h0;
		end
		else if (accept_en_in && request_in && gap == 2'h0)
		begin
			ack_out.accept <= 1'b1;
			ack_out.accept_level <= request_level_in;
			active[request_level_in] <= 1'b1;
			gap <= 2'h3;
		end
		else if (ret_go_in && |active)
		begin
			ack_out.ret <= 1'b1;
			ack_out.return_level <= top;
			active[top] <= 1'b0;
		end
	end
endmodule // core_pipe_model

/* File: sim/two_stage_event_controller_test.sv */
// Self-checking bench for the two-stage event controller
`timescale 1ns/1ps
module two_stage_event_controller_test;
	import event_ctrl_pkg::*;
	logic         clk_in;
	logic         rst_n_in;
	logic [31:0]  src;
	core_events_t evt;
	core_ack_t    ack;
	logic         g_on;
	logic         g_off;
	logic         idle;
	mmr_req_t     req;
	logic [31:0]  rdata;
	logic         mmr_ack;
	logic         request;
	logic [3:0]   level;
	logic         g_en;
	logic         wake;
	logic         acc_en;
	logic         ret_go;
	logic [31:0]  expq[$];
	logic [31:0]  r;
	int           bad_count;
	int           total_checks;
	int           n;

	two_stage_event_controller u_two_stage_event_controller
	(
		.clk_in(clk_in), .rst_n_in(rst_n_in), .source_req_in(src),
		.core_events_in(evt), .core_ack_in(ack), .global_on_in(g_on),
		.global_off_in(g_off), .idle_in(idle), .mmr_req_in(req),
		.mmr_rdata_out(rdata), .mmr_ack_out(mmr_ack), .request_out(request),
		.request_level_out(level), .global_enable_out(g_en), .wake_out(wake)
	);
	core_pipe_model u_core_pipe_model
	(
		.clk_in(clk_in), .rst_n_in(rst_n_in), .request_in(request),
		.request_level_in(level), .accept_en_in(acc_en), .ret_go_in(ret_go),
		.ack_out(ack)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic ok, input string msg);
	begin
		total_checks++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	end
	endtask
	task automatic cyc(input int k);
	begin
		repeat (k) @(negedge clk_in);
	end
	endtask
	task automatic mmr(input logic w, input logic s, input logic [3:0] i,
		input logic [31:0] d, input logic [31:0] e);
	begin
		@(negedge clk_in);
		expq.push_back(e);
		req = '{valid: 1'b1, write: w, supervisor: s, index: i, wdata: d};
		@(negedge clk_in);
		req.valid = 1'b0;
	end
	endtask
	task automatic rd(input logic [3:0] i, input logic [31:0] e);
	begin
		mmr(1'b0, 1'b1, i, 32'h00000000, e);
	end
	endtask
	task automatic wr(input logic [3:0] i, input logic [31:0] d);
	begin
		mmr(1'b1, 1'b1, i, d, 32'h00000000);
	end
	endtask
	task automatic gp(input logic on);
	begin
		@(negedge clk_in);
		g_on = on;
		g_off = !on;
		@(negedge clk_in);
		g_on = 1'b0;
		g_off = 1'b0;
	end
	endtask
	task automatic ret1;
	begin
		@(negedge clk_in);
		ret_go = 1'b1;
		@(negedge clk_in);
		ret_go = 1'b0;
	end
	endtask
	task automatic wait_req(input logic [3:0] lv, input int lo, input int hi);
	begin
		n = 0;
		while (!(request === 1'b1 && level === lv) && n < hi)
		begin
			@(negedge clk_in);
			n++;
		end
		chk(request === 1'b1 && level === lv && n >= lo,
			$sformatf("request level %0d after %0d", lv, n));
	end
	endtask
	task automatic end_of_test;
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	// ==========================================================
	// Read data monitor, oldest note first
	always @(negedge clk_in)
		if (mmr_ack === 1'b1)
		begin
			if (expq.size() == 0)
				chk(1'b0, "unexpected ack");
			else
			begin
				r = expq.pop_front();
				chk(rdata === r, $sformatf("read %h want %h", rdata, r));
			end
		end
	// ==========================================================
	// Watchdog
	initial
	begin
		#(4000 * 25);
		bad_count++;
		end_of_test;
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		rst_n_in = 1'b0;
		src = '0;
		evt = '0;
		g_on = 1'b0;
		g_off = 1'b0;
		idle = 1'b0;
		req = '0;
		acc_en = 1'b0;
		ret_go = 1'b0;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(32'h3f19c18e));
		cyc(8);
		rst_n_in = 1'b1;
		rd(IDX_LATCH, RESET_WORD);
		rd(IDX_MASK, 32'(RESET_CORE_MSK));
		rd(IDX_PENDING, RESET_WORD);
		rd(IDX_SYS_MSK, RESET_WORD);
		rd(IDX_SYS_WAK, RESET_WORD);
		rd(IDX_ASSIGN0 + 4'h1, DEFAULT_ASSIGN[63:32]);
		rd(4'hf, RESET_WORD);
		mmr(1'b1, 1'b0, IDX_MASK, 32'h0000ffff, RESET_WORD);
		mmr(1'b0, 1'b0, IDX_MASK, 32'h00000000, RESET_WORD);
		rd(IDX_MASK, 32'(RESET_CORE_MSK));
		repeat (4)
		begin
			src = $urandom;
			cyc(3);
			rd(IDX_SYS_STS, src);
		end
		src = '0;
		rd(IDX_LATCH, RESET_WORD);
		wr(IDX_SYS_MSK, 32'h00000001);
		rd(IDX_SYS_MSK, 32'h00000001);
		gp(1'b1);
		chk(g_en === 1'b1, "global enable not set");
		src[0] = 1'b1;
		cyc(5);
		chk(request === 1'b0, "masked level requested");
		rd(IDX_LATCH, 32'h00000080);
		mmr(1'b1, 1'b0, IDX_LATCH, 32'h00000080, RESET_WORD);
		wr(IDX_MASK, 32'h0000009f);
		wr(IDX_LATCH, 32'h00000080);
		rd(IDX_LATCH, 32'h00000080);
		chk(request === 1'b1 && level === 4'h7, "unmasked latch idle");
		gp(1'b0);
		cyc(2);
		chk(request === 1'b0 && g_en === 1'b0, "disabled level requested");
		wr(IDX_MASK, 32'h0000001f);
		wr(IDX_LATCH, 32'h00000080);
		rd(IDX_LATCH, RESET_WORD);
		src[0] = 1'b0;
		wr(IDX_MASK, 32'h0000009f);
		gp(1'b1);
		cyc(2);
		src[0] = 1'b1;
		wait_req(4'h7, 3, 8);
		acc_en = 1'b1;
		cyc(6);
		chk(request === 1'b0, "accepted event still requested");
		acc_en = 1'b0;
		rd(IDX_PENDING, 32'h00000080);
		rd(IDX_LATCH, 32'h00000080);
		mmr(1'b0, 1'b0, IDX_PENDING, 32'h00000000, RESET_WORD);
		evt.nmi = 1'b1;
		wait_req(4'h2, 1, 12);
		evt.nmi = 1'b0;
		acc_en = 1'b1;
		cyc(6);
		acc_en = 1'b0;
		rd(IDX_PENDING, 32'h00000084);
		ret1;
		rd(IDX_PENDING, 32'h00000080);
		ret1;
		wait_req(4'h7, 1, 8);
		src = '0;
		rst_n_in = 1'b0;
		cyc(4);
		rst_n_in = 1'b1;
		rd(IDX_PENDING, RESET_WORD);
		wr(IDX_SYS_MSK, 32'h00000006);
		wr(IDX_MASK, 32'h0000ffff);
		rd(IDX_MASK, 32'h0000ffff);
		wr(IDX_ASSIGN0, 32'h00000030);
		rd(IDX_ASSIGN0, 32'h00000030);
		wr(IDX_SYS_WAK, 32'h00000002);
		rd(IDX_SYS_WAK, 32'h00000002);
		gp(1'b1);
		idle = 1'b1;
		src[1] = 1'b1;
		wait_req(4'ha, 1, 8);
		chk(wake === 1'b1, "idle core not woken");
		src[2] = 1'b1;
		wait_req(4'h7, 1, 8);
		idle = 1'b0;
		cyc(3);
		chk(wake === 1'b0, "wake while busy");
		chk(expq.size() == 0, "read note left without ack");
		end_of_test;
	end
endmodule // two_stage_event_controller_test
